// [design/scip_irq_prioritizer.sv]
// Serial controller interrupt routing, acknowledge handling and level prioritizer
`timescale 1ns/1ps
// Functional notes
// - No serial controller selection for four-byte or sixteen-byte transfer sizes.
// - Modem, transmit and receive sources each have their own level.
// - Family select set: pending source shown on level pins at its level.
// - Family select clear: interrupt output only when level exceeds mask.
// - Auto-vector: device returns vector, no cycle to serial controller.
// - Direct mode forwards acknowledge with code 01, 02 or 03.
// - Pseudo-ack read start runs an acknowledge with the matching code.
// - Returned vector appears on low byte and bits 23 to 16.
// - After the vector is placed, transfer acknowledge ends the read.
// - Seven-level scheme, switched by the family select bit.
// - Family select set: highest pending internal level drives level pins.
// - Family select clear: merge pin level with internal, compare to mask.
// - Interrupt rises when merged level climbs above the mask.
// - Interrupt rises when mask is written below the merged level.
// - Gate low blocks all interrupts and passes acknowledges through.
// - Auto-vector nibbles B, C, D; transmit highest, then receive, modem.
// - Clearing a source's auto-vector bit selects direct vector fetch.
module scip_irq_prioritizer (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Configuration
    input wire logic cpu_family_select_i,
    input wire logic master_interrupt_gate_i,
    input wire logic [2:0] mask_level_i,
    input wire logic [2:0] modem_level_i,
    input wire logic [2:0] tx_level_i,
    input wire logic [2:0] rx_level_i,
    input wire logic [2:0] auto_vector_select_i,
    input wire logic [3:0] vector_base_i,
    // Status
    output logic [2:0] sc_irq_flags_o,
    // Local bus
    input wire logic lb_ts_i,
    input wire logic [31:0] lb_addr_i,
    input wire logic lb_read_i,
    input wire logic [1:0] lb_siz_i,
    input wire logic [1:0] lb_tt_i,
    output logic lb_ta_b_o,
    output logic [31:0] lb_data_o,
    output logic lb_data_oe_o,
    output logic acknowledge_passthrough_b_o,
    // Serial controller
    input wire logic [2:0] sc_irq_i,
    input wire logic sc_done_b_i,
    input wire logic [7:0] sc_vec_i,
    output logic sc_sel_o,
    output logic [7:0] sc_addr_o,
    output logic sc_addr_oe_o,
    output logic sc_ack_b_o,
    // Encoded priority level pins and single interrupt
    input wire logic [2:0] encoded_priority_level_b_i,
    output logic [2:0] encoded_priority_level_b_o,
    output logic encoded_priority_level_oe_o,
    output logic int_o
);
    scip_ack_if ack ();
    scip_pkg::scip_bus_st_e st_q;
    logic [2:0] irq_m_q, irq_s_q, epl_m_q, epl_s_q;
    logic [8:0] levels;
    logic [2:0] int_lvl, merged_lvl;
    logic [1:0] top_src;
    logic tt_ok, in_sc, in_csr, size_ok, is_pack, is_ack, av_take;
    logic [1:0] hit_src;
    logic hit_ok;
    logic [7:0] pack_code;
    logic [3:0] av_nib;

    assign levels = {rx_level_i, tx_level_i, modem_level_i};

    // Pins from outside pass two flops before use
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            irq_m_q <= 3'h0;
            irq_s_q <= 3'h0;
            epl_m_q <= scip_pkg::EPL_IDLE;
            epl_s_q <= scip_pkg::EPL_IDLE;
        end
        else
        begin
            irq_m_q <= sc_irq_i;
            irq_s_q <= irq_m_q;
            epl_m_q <= encoded_priority_level_b_i;
            epl_s_q <= epl_m_q;
        end
    end

    scip_level_merge u_merge (
        .gate_i(master_interrupt_gate_i),
        .pend_i(irq_s_q),
        .levels_i(levels),
        .ext_lvl_i(~epl_s_q),
        .use_ext_i(!cpu_family_select_i),
        .int_lvl_o(int_lvl),
        .merged_lvl_o(merged_lvl),
        .top_src_o(top_src)
    );

    scip_ack_seq u_seq (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .ack(ack.seq),
        .sc_done_b_i(sc_done_b_i),
        .sc_vec_i(sc_vec_i),
        .sc_addr_o(sc_addr_o),
        .sc_addr_oe_o(sc_addr_oe_o),
        .sc_ack_b_o(sc_ack_b_o)
    );

    // Level pins and interrupt output
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            encoded_priority_level_b_o <= scip_pkg::EPL_IDLE;
            encoded_priority_level_oe_o <= 1'b0;
            int_o <= 1'b0;
            sc_irq_flags_o <= 3'h0;
        end
        else
        begin
            sc_irq_flags_o <= irq_s_q;
            // Pins are driven only as outputs in family-select mode
            encoded_priority_level_oe_o <= cpu_family_select_i;
            encoded_priority_level_b_o <= ~int_lvl;
            // Level compare covers both a rising request and a lowered mask
            int_o <= !cpu_family_select_i && master_interrupt_gate_i
                && merged_lvl > mask_level_i;
        end
    end

    // Bus decode
    always_comb
    begin
        tt_ok = lb_tt_i == scip_pkg::TT_NORMAL || lb_tt_i == scip_pkg::TT_LINE;
        is_ack = lb_tt_i == scip_pkg::TT_ACK;
        in_sc = lb_addr_i[31:12] == scip_pkg::SC_PAGE;
        in_csr = lb_addr_i[31:12] == scip_pkg::CSR_PAGE;
        size_ok = lb_siz_i != scip_pkg::SIZ_LONG && lb_siz_i != scip_pkg::SIZ_LINE;
        pack_code = 8'h00;
        case (lb_addr_i[5:0])
            scip_pkg::PACK_MODEM_OFS: pack_code = scip_pkg::ACK_CODE_MODEM;
            scip_pkg::PACK_TX_OFS: pack_code = scip_pkg::ACK_CODE_TX;
            scip_pkg::PACK_RX_OFS: pack_code = scip_pkg::ACK_CODE_RX;
            default: pack_code = 8'h00;
        endcase
        is_pack = tt_ok && in_csr && lb_read_i && pack_code != 8'h00;
        // Pending source at the acknowledged level, same tie order as the merge
        hit_ok = 1'b0;
        hit_src = scip_pkg::SRC_MODEM;
        for (int k = 0; k < 3; k++)
        begin
            if (irq_s_q[scip_pkg::scip_rank(k)]
                && scip_pkg::scip_lvl(levels, scip_pkg::scip_rank(k)) == lb_addr_i[3:1]
                && lb_addr_i[3:1] != scip_pkg::LVL_NONE)
            begin
                hit_ok = 1'b1;
                hit_src = scip_pkg::scip_rank(k);
            end
        end
        case (hit_src)
            scip_pkg::SRC_TX: av_nib = scip_pkg::AV_TX;
            scip_pkg::SRC_RX: av_nib = scip_pkg::AV_RX;
            default: av_nib = scip_pkg::AV_MODEM;
        endcase
        av_take = st_q == scip_pkg::BUS_IDLE && lb_ts_i && is_ack
            && master_interrupt_gate_i && hit_ok && auto_vector_select_i[hit_src];
    end

    // Bus sequencing
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            st_q <= scip_pkg::BUS_IDLE;
            lb_ta_b_o <= 1'b1;
            lb_data_o <= 32'h0000_0000;
            lb_data_oe_o <= 1'b0;
            acknowledge_passthrough_b_o <= 1'b1;
            sc_sel_o <= 1'b0;
            ack.start <= 1'b0;
            ack.code <= 8'h00;
        end
        else
        begin
            lb_ta_b_o <= 1'b1;
            acknowledge_passthrough_b_o <= 1'b1;
            sc_sel_o <= 1'b0;
            ack.start <= 1'b0;
            case (st_q)
                scip_pkg::BUS_IDLE:
                begin
                    lb_data_oe_o <= 1'b0;
                    if (lb_ts_i)
                    begin
                        if (is_ack)
                        begin
                            if (!master_interrupt_gate_i || !hit_ok)
                            begin
                                acknowledge_passthrough_b_o <= 1'b0;
                            end
                            else if (auto_vector_select_i[hit_src])
                            begin
                                lb_data_o <= {24'h000000, vector_base_i, av_nib};
                                lb_data_oe_o <= 1'b1;
                                st_q <= scip_pkg::BUS_ANSWER;
                            end
                            else
                            begin
                                // Direct mode lets the controller clear its own request
                                ack.start <= 1'b1;
                                ack.code <= 8'(hit_src) + 8'h01;
                                st_q <= scip_pkg::BUS_FWD;
                            end
                        end
                        else if (is_pack)
                        begin
                            ack.start <= 1'b1;
                            ack.code <= pack_code;
                            st_q <= scip_pkg::BUS_FWD;
                        end
                        else if (tt_ok && in_sc && size_ok)
                        begin
                            sc_sel_o <= 1'b1;
                        end
                    end
                end
                scip_pkg::BUS_FWD:
                begin
                    if (ack.done)
                    begin
                        lb_data_o <= {8'h00, ack.vec, 8'h00, ack.vec};
                        lb_data_oe_o <= 1'b1;
                        st_q <= scip_pkg::BUS_ANSWER;
                    end
                end
                scip_pkg::BUS_ANSWER:
                begin
                    lb_ta_b_o <= 1'b0;
                    st_q <= scip_pkg::BUS_IDLE;
                end
                default: st_q <= scip_pkg::BUS_IDLE;
            endcase
        end
    end

    a_size_no_select: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_q == scip_pkg::BUS_IDLE && lb_ts_i && in_sc && !size_ok) |=> !sc_sel_o)
        else $error("serial region selected with unsupported size");
    a_tt_select_only: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        sc_sel_o |-> $past(tt_ok) && $past(lb_ts_i))
        else $error("selection with wrong transfer type");
    a_level_pins_out: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ($past(rst_b_i) && cpu_family_select_i && $past(cpu_family_select_i)) |->
        (encoded_priority_level_oe_o && encoded_priority_level_b_o == ~$past(int_lvl)))
        else $error("level pins do not carry highest internal level");
    a_int_over_mask: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        int_o |-> ($past(merged_lvl) > $past(mask_level_i) && !$past(cpu_family_select_i)
        && $past(master_interrupt_gate_i)))
        else $error("interrupt without level above mask");
    a_mask_lowered_int: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!cpu_family_select_i && master_interrupt_gate_i && merged_lvl > mask_level_i)
        |=> int_o)
        else $error("interrupt not raised for level above mask");
    a_gate_blocks_all: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !master_interrupt_gate_i |=> (!int_o && encoded_priority_level_b_o == 3'h7))
        else $error("interrupt leaked with gate low");
    a_auto_no_forward: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        av_take |=> (!ack.start && lb_data_o[3:0] == $past(av_nib)) ##1 !lb_ta_b_o)
        else $error("auto-vector answer wrong or forwarded");
    a_vector_lanes: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_q == scip_pkg::BUS_FWD && ack.done) |=>
        (lb_data_o[7:0] == $past(ack.vec) && lb_data_o[23:16] == $past(ack.vec)))
        else $error("vector not on both byte lanes");
    a_ta_after_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_q == scip_pkg::BUS_ANSWER) |=> (!lb_ta_b_o && lb_data_oe_o))
        else $error("transfer acknowledge missing after vector");
    // Ties fall to transmit, as the acknowledge decode assumes the same order
    a_tx_top_rank: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (master_interrupt_gate_i && irq_s_q[scip_pkg::SRC_TX]
        && tx_level_i != scip_pkg::LVL_NONE
        && tx_level_i >= rx_level_i && tx_level_i >= modem_level_i)
        |-> (top_src == scip_pkg::SRC_TX && int_lvl == tx_level_i))
        else $error("transmit request not ranked highest");
    a_pack_code_fwd: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_q == scip_pkg::BUS_IDLE && lb_ts_i && is_pack) |=>
        (ack.start && ack.code == $past(pack_code) && st_q == scip_pkg::BUS_FWD))
        else $error("pseudo acknowledge read not forwarded");
    a_gate_passes_ack: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_q == scip_pkg::BUS_IDLE && lb_ts_i && is_ack && !master_interrupt_gate_i) |=>
        (!acknowledge_passthrough_b_o && !ack.start && lb_data_oe_o == 1'b0))
        else $error("acknowledge not passed on with gate low");
    a_pins_as_inputs: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !cpu_family_select_i |=> !encoded_priority_level_oe_o)
        else $error("level pins driven with family select clear");
    a_size_ok_select: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_q == scip_pkg::BUS_IDLE && lb_ts_i && tt_ok && in_sc && size_ok) |=> sc_sel_o)
        else $error("serial region not selected for supported access");
endmodule // scip_irq_prioritizer

// [design/scip_pkg.sv]
// Shared constants, types and helpers for the serial interrupt prioritizer
package scip_pkg;
    // Source indices
    localparam logic [1:0] SRC_MODEM = 2'h0;
    localparam logic [1:0] SRC_TX = 2'h1;
    localparam logic [1:0] SRC_RX = 2'h2;
    // Acknowledge address codes towards the serial controller
    localparam logic [7:0] ACK_CODE_MODEM = 8'h01;
    localparam logic [7:0] ACK_CODE_TX = 8'h02;
    localparam logic [7:0] ACK_CODE_RX = 8'h03;
    // Auto-vector low nibbles
    localparam logic [3:0] AV_MODEM = 4'hb;
    localparam logic [3:0] AV_RX = 4'hc;
    localparam logic [3:0] AV_TX = 4'hd;
    // Transfer types and sizes
    localparam logic [1:0] TT_NORMAL = 2'h0;
    localparam logic [1:0] TT_LINE = 2'h1;
    localparam logic [1:0] TT_ACK = 2'h3;
    localparam logic [1:0] SIZ_LONG = 2'h0;
    localparam logic [1:0] SIZ_LINE = 2'h3;
    // Address decode
    localparam logic [19:0] CSR_PAGE = 20'hfff42;
    localparam logic [19:0] SC_PAGE = 20'hfff45;
    localparam logic [5:0] PACK_MODEM_OFS = 6'h23;
    localparam logic [5:0] PACK_TX_OFS = 6'h25;
    localparam logic [5:0] PACK_RX_OFS = 6'h27;
    // Reset values
    localparam logic [2:0] EPL_IDLE = 3'h7;
    localparam logic [2:0] LVL_NONE = 3'h0;

    typedef enum logic [1:0] {BUS_IDLE, BUS_FWD, BUS_ANSWER} scip_bus_st_e;
    typedef enum logic {SEQ_IDLE, SEQ_WAIT} scip_seq_st_e;

    // Level of one source out of the packed {rx, tx, modem} field
    function automatic logic [2:0] scip_lvl(input logic [8:0] lv, input logic [1:0] s);
        scip_lvl = lv[3*s +: 3];
    endfunction

    // Priority rank to source: ties go to transmit, then receive, then modem
    function automatic logic [1:0] scip_rank(input int k);
        case (k)
            0: scip_rank = SRC_MODEM;
            1: scip_rank = SRC_RX;
            default: scip_rank = SRC_TX;
        endcase
    endfunction
endpackage

// [design/scip_ack_if.sv]
// Request and answer bundle between the bus sequencer and the acknowledge engine
`timescale 1ns/1ps
interface scip_ack_if;
    logic start;
    logic [7:0] code;
    logic done;
    logic [7:0] vec;
    modport req (output start, output code, input done, input vec);
    modport seq (input start, input code, output done, output vec);
endinterface

// [design/scip_level_merge.sv]
// Internal level selection and merge with the incoming external level
`timescale 1ns/1ps
module scip_level_merge (
    // Sources
    input wire logic gate_i,
    input wire logic [2:0] pend_i,
    input wire logic [8:0] levels_i,
    // External level, already decoded to a number
    input wire logic [2:0] ext_lvl_i,
    input wire logic use_ext_i,
    // Results
    output logic [2:0] int_lvl_o,
    output logic [2:0] merged_lvl_o,
    output logic [1:0] top_src_o
);
    logic [1:0] s;
    logic [2:0] l;

    always_comb
    begin
        s = scip_pkg::SRC_MODEM;
        l = scip_pkg::LVL_NONE;
        int_lvl_o = scip_pkg::LVL_NONE;
        top_src_o = scip_pkg::SRC_MODEM;
        // Later ranks win ties, so transmit outranks receive outranks modem
        for (int k = 0; k < 3; k++)
        begin
            s = scip_pkg::scip_rank(k);
            l = scip_pkg::scip_lvl(levels_i, s);
            if (gate_i && pend_i[s] && l != scip_pkg::LVL_NONE && l >= int_lvl_o)
            begin
                int_lvl_o = l;
                top_src_o = s;
            end
        end
        merged_lvl_o = int_lvl_o;
        if (use_ext_i && ext_lvl_i > int_lvl_o)
        begin
            merged_lvl_o = ext_lvl_i;
        end
    end
endmodule // scip_level_merge

// [design/scip_ack_seq.sv]
// Acknowledge cycle engine towards the serial controller
`timescale 1ns/1ps
module scip_ack_seq (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Request side
    scip_ack_if.seq ack,
    // Serial controller pins
    input wire logic sc_done_b_i,
    input wire logic [7:0] sc_vec_i,
    output logic [7:0] sc_addr_o,
    output logic sc_addr_oe_o,
    output logic sc_ack_b_o
);
    scip_pkg::scip_seq_st_e st_q;
    logic done_m_q, done_s_q;
    logic [7:0] vec_m_q, vec_s_q;

    // Pin inputs pass two flops
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            done_m_q <= 1'b1;
            done_s_q <= 1'b1;
            vec_m_q <= 8'h00;
            vec_s_q <= 8'h00;
        end
        else
        begin
            done_m_q <= sc_done_b_i;
            done_s_q <= done_m_q;
            vec_m_q <= sc_vec_i;
            vec_s_q <= vec_m_q;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            st_q <= scip_pkg::SEQ_IDLE;
            sc_addr_o <= 8'h00;
            sc_addr_oe_o <= 1'b0;
            sc_ack_b_o <= 1'b1;
            ack.done <= 1'b0;
            ack.vec <= 8'h00;
        end
        else
        begin
            ack.done <= 1'b0;
            case (st_q)
                scip_pkg::SEQ_IDLE:
                begin
                    if (ack.start)
                    begin
                        sc_addr_o <= ack.code;
                        sc_addr_oe_o <= 1'b1;
                        sc_ack_b_o <= 1'b0;
                        st_q <= scip_pkg::SEQ_WAIT;
                    end
                end
                scip_pkg::SEQ_WAIT:
                begin
                    // Vector is stable once the controller signals done
                    if (!done_s_q)
                    begin
                        ack.vec <= vec_s_q;
                        ack.done <= 1'b1;
                        sc_addr_oe_o <= 1'b0;
                        sc_ack_b_o <= 1'b1;
                        st_q <= scip_pkg::SEQ_IDLE;
                    end
                end
                default: st_q <= scip_pkg::SEQ_IDLE;
            endcase
        end
    end

    a_fwd_code_drive: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_q == scip_pkg::SEQ_IDLE && ack.start) |=>
        (sc_addr_o == $past(ack.code) && !sc_ack_b_o && sc_addr_oe_o))
        else $error("acknowledge code not driven to serial controller");
endmodule // scip_ack_seq

// [testbench/scip_sc_model.sv]
// Behavioural serial controller that answers forwarded acknowledge cycles
`timescale 1ns/1ps
module scip_sc_model (
    // Clock
    input wire logic sys_clk_i,
    // Acknowledge pins
    input wire logic sc_ack_b_i,
    input wire logic [7:0] sc_addr_i,
    input wire logic [3:0] delay_i,
    output logic sc_done_b_o,
    output logic [7:0] sc_vec_o
);
    logic [3:0] cnt_q;
    initial
    begin
        sc_done_b_o = 1'b1;
        sc_vec_o = 8'ha5;
        cnt_q = 4'h0;
    end
    // Done is held for as long as the acknowledge lasts, so it covers the synchroniser
    always @(posedge sys_clk_i)
    begin
        if (sc_ack_b_i !== 1'b0)
        begin
            sc_done_b_o <= 1'b1;
            cnt_q <= 4'h0;
            // Released vector bus toggles, so it shows the last answer only on alternate cycles
            sc_vec_o <= ~sc_vec_o;
        end
        else
        begin
            // Vector settles ahead of done, so the synchronised word is whole when seen
            sc_vec_o <= 8'h50 | sc_addr_i;
            if (cnt_q < delay_i)
                cnt_q <= cnt_q + 4'h1;
            else
                sc_done_b_o <= 1'b0;
        end
    end
endmodule // scip_sc_model

// [testbench/scip_irq_prioritizer_test.sv]
// Self-checking bench for the serial interrupt prioritizer
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module scip_irq_prioritizer_test;
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, fam = 1'b0, gate = 1'b0, ts = 1'b0, rd = 1'b0;
    logic [2:0] mask = 3'h7, lv_m = 3'h2, lv_t = 3'h5, lv_r = 3'h3, avs = 3'h0, irq = 3'h0;
    logic [2:0] ext_b = 3'h7, flags, epl_out, epl_pin;
    logic [3:0] vbase = 4'h6, dly = 4'h1;
    logic [31:0] addr = 32'h0, data;
    logic [1:0] siz = 2'h1, tt = 2'h0;
    logic ta_b, doe, pass_b, sel, aoe, sc_ack_b, done_b, epl_oe, int_q;
    logic [7:0] sc_addr, vec;
    int failures = 0, checked = 0;
    logic [2:0] lvl [3];
    logic [7:0] code [3];
    logic [3:0] nib [3];

    always #2.5 sys_clk_i = ~sys_clk_i;
    // Outside logic merges its sources onto the pins; pull-ups leave them high
    assign epl_pin = epl_oe ? epl_out : ext_b;

    scip_irq_prioritizer dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .cpu_family_select_i(fam), .master_interrupt_gate_i(gate), .mask_level_i(mask),
        .modem_level_i(lv_m), .tx_level_i(lv_t), .rx_level_i(lv_r),
        .auto_vector_select_i(avs), .vector_base_i(vbase), .sc_irq_flags_o(flags),
        .lb_ts_i(ts), .lb_addr_i(addr), .lb_read_i(rd), .lb_siz_i(siz), .lb_tt_i(tt),
        .lb_ta_b_o(ta_b), .lb_data_o(data), .lb_data_oe_o(doe),
        .acknowledge_passthrough_b_o(pass_b), .sc_irq_i(irq), .sc_done_b_i(done_b),
        .sc_vec_i(vec), .sc_sel_o(sel), .sc_addr_o(sc_addr), .sc_addr_oe_o(aoe),
        .sc_ack_b_o(sc_ack_b), .encoded_priority_level_b_i(epl_pin),
        .encoded_priority_level_b_o(epl_out), .encoded_priority_level_oe_o(epl_oe),
        .int_o(int_q));

    scip_sc_model sc_u (.sys_clk_i(sys_clk_i), .sc_ack_b_i(sc_ack_b), .sc_addr_i(sc_addr),
        .delay_i(dly), .sc_done_b_o(done_b), .sc_vec_o(vec));

    task automatic end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Returns in the edge's time step: outputs still show what the last edge launched
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // One-cycle start pulse; returns in the step of the taking edge
    task automatic xfer(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] t);
        @(posedge sys_clk_i);
        ts <= 1'b1;
        addr <= a;
        rd <= 1'b1;
        siz <= sz;
        tt <= t;
        @(posedge sys_clk_i);
        ts <= 1'b0;
    endtask

    // Waits for the transfer acknowledge, noting any forwarded cycle on the way
    task automatic wait_ta(output logic [31:0] d, output logic [7:0] c, output logic f);
        f = 1'b0;
        c = 8'h00;
        for (int i = 0; i < 60; i++)
        begin
            cyc(1);
            if (sc_ack_b === 1'b0)
            begin
                f = 1'b1;
                c = sc_addr;
                `CHK(aoe, 1'b1)
            end
            if (ta_b === 1'b0)
                break;
        end
        `CHK(ta_b, 1'b0)
        `CHK(doe, 1'b1)
        d = data;
    endtask

    task automatic t_reset;
        `CHK({ta_b, pass_b, sc_ack_b, doe, int_q, sel}, 6'h38)
        `CHK(epl_out, 3'h7)
    endtask

    task automatic t_pack;
        logic [31:0] d;
        logic [7:0] c;
        logic f;
        irq <= 3'h7;
        for (int i = 0; i < 20 && flags !== 3'h7; i++)
            cyc(1);
        // Polling waits for the request flags before reading
        `CHK(flags, 3'h7)
        for (int s = 0; s < 3; s++)
        begin
            dly <= (s == 1) ? 4'h7 : 4'h1;
            xfer(32'hfff42023 + 32'(2 * s), 2'h1, scip_pkg::TT_NORMAL);
            wait_ta(d, c, f);
            `CHK(c, code[s])
            `CHK(d, {8'h00, 8'h50 | code[s], 8'h00, 8'h50 | code[s]})
        end
    endtask

    task automatic t_ack;
        logic [31:0] d;
        logic [7:0] c;
        logic f;
        // Direct mode first: the controller supplies its vector
        for (int m = 0; m < 2; m++)
            for (int s = 0; s < 3; s++)
            begin
                avs <= (m == 1) ? 3'(1 << s) : 3'h0;
                cyc(1);
                xfer({28'h0, lvl[s], 1'b0}, 2'h1, scip_pkg::TT_ACK);
                wait_ta(d, c, f);
                if (m == 1)
                begin
                    `CHK(f, 1'b0)
                    `CHK(d, {24'h0, vbase, nib[s]})
                end
                else
                begin
                    `CHK(c, code[s])
                    `CHK(d, {8'h00, 8'h50 | code[s], 8'h00, 8'h50 | code[s]})
                end
            end
    endtask

    task automatic t_refuse;
        for (int z = 0; z < 4; z++)
        begin
            xfer(32'hfff45010, 2'(z), scip_pkg::TT_NORMAL);
            cyc(1);
            `CHK(sel, (z == 1 || z == 2))
            cyc(3);
        end
        for (int t = 0; t < 3; t++)
        begin
            xfer(32'hfff45010, 2'h1, 2'(t));
            cyc(1);
            `CHK(sel, (t != 2))
            cyc(3);
        end
    endtask

    task automatic t_family;
        fam <= 1'b1;
        cyc(6);
        `CHK(epl_oe, 1'b1)
        `CHK(epl_out, ~3'h5)
        irq <= 3'b101;
        cyc(6);
        `CHK(epl_out, ~3'h3)
        gate <= 1'b0;
        cyc(6);
        `CHK(epl_out, 3'h7)
        xfer(32'h0000000a, 2'h1, scip_pkg::TT_ACK);
        cyc(1);
        `CHK(pass_b, 1'b0)
        `CHK(sc_ack_b, 1'b1)
        cyc(3);
    endtask

    task automatic t_mask;
        fam <= 1'b0;
        gate <= 1'b1;
        irq <= 3'h7;
        mask <= 3'h6;
        cyc(6);
        `CHK(int_q, 1'b0)
        ext_b <= 3'h0;
        cyc(6);
        `CHK(int_q, 1'b1)
        ext_b <= 3'h7;
        cyc(6);
        `CHK(int_q, 1'b0)
        mask <= 3'h4;
        cyc(3);
        `CHK(int_q, 1'b1)
        irq <= 3'h0;
        mask <= 3'h0;
        cyc(6);
        `CHK(int_q, 1'b0)
    endtask

    initial
    begin
        #100000;
        failures++;
        end_of_test();
    end

    initial
    begin
        lvl = '{lv_m, lv_t, lv_r};
        code = '{scip_pkg::ACK_CODE_MODEM, scip_pkg::ACK_CODE_TX, scip_pkg::ACK_CODE_RX};
        nib = '{scip_pkg::AV_MODEM, scip_pkg::AV_TX, scip_pkg::AV_RX};
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        gate <= 1'b1;
        cyc(1);
        t_reset();
        t_pack();
        t_ack();
        t_refuse();
        t_family();
        t_mask();
        end_of_test();
    end
endmodule // scip_irq_prioritizer_test
